// ### fsd_pkg.sv
// shared constants for the fault status dump serializer
package fsd_pkg;
    localparam int FSD_CNT_W = 4;
    localparam logic [3:0] FSD_CNT_PRESET = 4'h7;
    localparam logic [3:0] FSD_CNT_LAST = 4'h4;
    localparam int FSD_SYS_CLK_HZ = 10_000_000;
    localparam int FSD_STAT_CLK_HZ = 250_000;
    localparam int FSD_HALF_DIV = FSD_SYS_CLK_HZ / (2 * FSD_STAT_CLK_HZ);
    localparam int FSD_DUMP_PERIODS = 13;
    localparam int FSD_VOLTAGE_MONITOR_N = 12;
    localparam int FSD_LINE0_IO_N = 5;
    localparam int FSD_LINE1_IO_N = 5;
    localparam int FSD_LINE2_IO_N = 5;
endpackage

// ### fsd_clkgen.sv
// divider that makes the 250 kHz status clock and its rising-edge tick
module fsd_clkgen #(
    parameter int HALF_DIV = fsd_pkg::FSD_HALF_DIV
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // status clock
    output logic stat_clk_o,
    output logic rise_tick_o
);
    import fsd_pkg::*;

    logic [7:0] div_reg;
    logic stat_clk_reg;
    logic tick_reg;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            div_reg <= 8'h00;
            stat_clk_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else if (div_reg == 8'(HALF_DIV - 1)) begin
            div_reg <= 8'h00;
            stat_clk_reg <= ~stat_clk_reg;
            tick_reg <= ~stat_clk_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    assign stat_clk_o = stat_clk_reg;
    assign rise_tick_o = tick_reg;
endmodule // fsd_clkgen

// ### fsd_serializer.sv
// fault status dump: counter, status-line decode and status clock
// Behaviour
// - counter held at 7 while dump request high
// - counter counts 8..15,0..4 once per status clock period
// - counting only while dump request is low
// - at count 4 dump request returns high, one dump per fault
// - status clock 250 kHz made inside, drives logic and goes out
// - status lines change on rising status clock edge while counting
// - status lines are decodes of count, one input bit per count
// - whole dump takes 13 status clock periods
// - capture strobe equals counter msb; receiver starts on its rise
// - line zero: monitors 1-4 A/B, then hv outputs 1-4, output 5
// - line one: monitors 5-8 A/B, A at even counts
// - line two: monitors 9-12 A/B, then output 12, inputs 1-4
// - request high at start-up, low on fault until count 4
module fsd_serializer (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // fault request from the monitoring sequence (pin, asynchronous)
    input wire logic fault_i,
    // monitor results, bit k-1 is monitor k
    input wire logic [fsd_pkg::FSD_VOLTAGE_MONITOR_N-1:0] voltage_monitor_a_i,
    input wire logic [fsd_pkg::FSD_VOLTAGE_MONITOR_N-1:0] voltage_monitor_b_i,
    // io status for counts 0..4, per line
    input wire logic [fsd_pkg::FSD_LINE0_IO_N-1:0] line0_io_i,
    input wire logic [fsd_pkg::FSD_LINE1_IO_N-1:0] line1_io_i,
    input wire logic [fsd_pkg::FSD_LINE2_IO_N-1:0] line2_io_i,
    // link to the receiver
    output logic status_clk_o,
    output logic capture_strobe_o,
    output logic status_line_zero_o,
    output logic status_line_one_o,
    output logic status_line_two_o,
    output logic dump_request_n_o,
    output logic [3:0] dump_count_o
);
    import fsd_pkg::*;

    typedef enum logic [1:0] {
        FSD_IDLE = 2'b00,
        FSD_DUMP = 2'b01,
        FSD_WAIT = 2'b10
    } fsd_state_t;

    fsd_state_t state_reg;
    fsd_state_t state_next;
    logic fault_s1_reg;
    logic fault_s2_reg;
    logic stat_clk;
    logic rise_tick;
    logic dump_request_n_reg;
    logic [3:0] count_reg;
    logic status_clk_reg;
    logic strobe_reg;
    logic [2:0] lines_reg;

    // one status line: monitor pair at counts 8..15, io at 0..4
    function automatic logic line_decode(input logic [3:0] cnt,
                                         input logic [3:0] mon_a,
                                         input logic [3:0] mon_b,
                                         input logic [4:0] io);
        logic r;
        r = 1'b0;
        if (cnt[3]) begin
            r = cnt[0] ? mon_b[cnt[2:1]] : mon_a[cnt[2:1]];
        end else if (cnt <= FSD_CNT_LAST) begin
            r = io[cnt[2:0]];
        end
        return r;
    endfunction

    fsd_clkgen #(
        .HALF_DIV(FSD_HALF_DIV)
    ) u_clkgen (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .stat_clk_o(stat_clk),
        .rise_tick_o(rise_tick)
    );

    // fault pin synchroniser
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fault_s1_reg <= 1'b0;
            fault_s2_reg <= 1'b0;
        end else begin
            fault_s1_reg <= fault_i;
            fault_s2_reg <= fault_s1_reg;
        end
    end

    // request sequence: idle, dump, wait for fault to clear
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FSD_IDLE: begin
                if (fault_s2_reg && rise_tick) begin
                    state_next = FSD_DUMP;
                end
            end
            FSD_DUMP: begin
                if (rise_tick && count_reg == FSD_CNT_LAST) begin
                    state_next = FSD_WAIT;
                end
            end
            FSD_WAIT: begin
                if (!fault_s2_reg) begin
                    state_next = FSD_IDLE;
                end
            end
            default: state_next = FSD_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_reg <= FSD_IDLE;
            dump_request_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            dump_request_n_reg <= (state_next != FSD_DUMP);
        end
    end

    // dump counter, stepped on status clock rising edges
    // preset lands with the rising request, so 4 never steps on to 5
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            count_reg <= FSD_CNT_PRESET;
        end else if (dump_request_n_reg || state_next != FSD_DUMP) begin
            count_reg <= FSD_CNT_PRESET;
        end else if (rise_tick) begin
            count_reg <= count_reg + 4'h1;
        end
    end

    // link outputs, all registered
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            status_clk_reg <= 1'b0;
            strobe_reg <= 1'b0;
            lines_reg <= 3'h0;
        end else begin
            status_clk_reg <= stat_clk;
            strobe_reg <= count_reg[3];
            lines_reg[0] <= line_decode(count_reg, voltage_monitor_a_i[3:0],
                voltage_monitor_b_i[3:0], line0_io_i);
            lines_reg[1] <= line_decode(count_reg, voltage_monitor_a_i[7:4],
                voltage_monitor_b_i[7:4], line1_io_i);
            lines_reg[2] <= line_decode(count_reg, voltage_monitor_a_i[11:8],
                voltage_monitor_b_i[11:8], line2_io_i);
        end
    end

    assign status_clk_o = status_clk_reg;
    assign capture_strobe_o = strobe_reg;
    assign status_line_zero_o = lines_reg[0];
    assign status_line_one_o = lines_reg[1];
    assign status_line_two_o = lines_reg[2];
    assign dump_request_n_o = dump_request_n_reg;
    assign dump_count_o = count_reg;

    // assertions
    int unsigned run_len_reg;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || dump_request_n_reg) begin
            run_len_reg <= 0;
        end else if (rise_tick && state_next == FSD_DUMP) begin
            run_len_reg <= run_len_reg + 1;
        end
    end

    sequence s_last_step;
        rise_tick && count_reg == FSD_CNT_LAST && !dump_request_n_reg;
    endsequence

    property p_preset;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $past(dump_request_n_reg) |-> count_reg == FSD_CNT_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("count not preset");

    property p_step;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rise_tick && !dump_request_n_reg && state_next == FSD_DUMP)
            |=> count_reg == $past(count_reg) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("count missed a step");

    property p_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !rise_tick && !$past(dump_request_n_reg) |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved off edge");

    property p_end;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_last_step |=> dump_request_n_reg ##1 count_reg == FSD_CNT_PRESET;
    endproperty
    a_end: assert property (p_end) else $error("dump did not end at 4");

    property p_clk;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $rose(stat_clk) |-> ##20 $fell(stat_clk);
    endproperty
    a_clk: assert property (p_clk) else $error("status clock period");

    property p_strobe;
        @(posedge mclk_i) disable iff (!reset_n_i)
        ##1 capture_strobe_o == $past(count_reg[3]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not msb");

    property p_len;
        @(posedge mclk_i) disable iff (!reset_n_i)
        run_len_reg <= FSD_DUMP_PERIODS;
    endproperty
    a_len: assert property (p_len) else $error("dump too long");

    property p_len_exact;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_last_step |-> run_len_reg == FSD_DUMP_PERIODS;
    endproperty
    a_len_exact: assert property (p_len_exact) else $error("dump length");

    property p_range;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !(count_reg inside {4'h5, 4'h6});
    endproperty
    a_range: assert property (p_range) else $error("count out of range");

    property p_idle_low;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $past(dump_request_n_reg, 2) && $past(dump_request_n_reg)
            |-> lines_reg == 3'h0;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("lines busy idle");

    property p_line0_io;
        @(posedge mclk_i) disable iff (!reset_n_i)
        count_reg == 4'h0 |=> status_line_zero_o == $past(line0_io_i[0]);
    endproperty
    a_line0_io: assert property (p_line0_io) else $error("line0 io");
endmodule // fsd_serializer

// ### fsd_rx_model.sv
// receiver model: captures one status dump on falling status clock edges
module fsd_rx_model (
    // link from the serializer
    input wire logic status_clk_i,
    input wire logic capture_strobe_i,
    input wire logic [2:0] lines_i,
    // captured frame, three bits per period
    output logic [38:0] frame_o,
    output int dumps_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic strobe_prev = 1'b0;
    int bit_cnt = 0;
    initial dumps_o = 0;
    always @(negedge status_clk_i) begin
        if (bit_cnt == 0 && capture_strobe_i && !strobe_prev) begin
            frame_o[2:0] = lines_i;
            bit_cnt = 1;
        end else if (bit_cnt != 0) begin
            frame_o[3*bit_cnt+:3] = lines_i;
            bit_cnt = bit_cnt + 1;
            if (bit_cnt == 13) begin
                bit_cnt = 0;
                dumps_o = dumps_o + 1;
            end
        end
        strobe_prev = capture_strobe_i;
    end
endmodule // fsd_rx_model

// ### tb.sv
// self-checking bench for the fault status dump serializer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fsd_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic fault_i = 1'b0;
    logic [FSD_VOLTAGE_MONITOR_N-1:0] vm_a = '0;
    logic [FSD_VOLTAGE_MONITOR_N-1:0] vm_b = '0;
    logic [4:0] io0 = 5'h00;
    logic [4:0] io1 = 5'h00;
    logic [4:0] io2 = 5'h00;
    logic stat_clk, strobe, req_n;
    logic [2:0] lines;
    logic [3:0] count;
    logic [38:0] frame;
    int dumps;
    int error_cnt = 0;
    int n_compared = 0;
    fsd_serializer fsd_serializer_inst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .fault_i(fault_i),
        .voltage_monitor_a_i(vm_a), .voltage_monitor_b_i(vm_b),
        .line0_io_i(io0), .line1_io_i(io1), .line2_io_i(io2),
        .status_clk_o(stat_clk), .capture_strobe_o(strobe),
        .status_line_zero_o(lines[0]), .status_line_one_o(lines[1]),
        .status_line_two_o(lines[2]), .dump_request_n_o(req_n),
        .dump_count_o(count)
    );
    fsd_rx_model fsd_rx_model_inst (
        .status_clk_i(stat_clk), .capture_strobe_i(strobe),
        .lines_i(lines), .frame_o(frame), .dumps_o(dumps)
    );
    initial forever #50 mclk_i = ~mclk_i;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [38:0] exp_frame();
        logic [38:0] f;
        int m;
        for (int i = 0; i < 13; i++) begin
            m = i / 2;
            if (i >= 8) f[3*i+:3] = {io2[i-8], io1[i-8], io0[i-8]};
            else if (i % 2 == 0) f[3*i+:3] = {vm_a[8+m], vm_a[4+m], vm_a[m]};
            else f[3*i+:3] = {vm_b[8+m], vm_b[4+m], vm_b[m]};
        end
        return f;
    endfunction
    task chk_idle();
        chk({count, req_n, strobe, lines}, {FSD_CNT_PRESET, 5'h10});
    endtask
    task t_clock();
        time t0;
        @(posedge stat_clk);
        t0 = $time;
        @(posedge stat_clk);
        chk($time - t0, 2 * FSD_HALF_DIV * 100);
    endtask
    task run_dump(input logic [11:0] a, input logic [11:0] b,
                  input logic [4:0] i0, input logic [4:0] i1,
                  input logic [4:0] i2);
        time t0;
        int d0;
        @(posedge mclk_i);
        vm_a <= a;
        vm_b <= b;
        io0 <= i0;
        io1 <= i1;
        io2 <= i2;
        fault_i <= 1'b1;
        d0 = dumps;
        @(posedge strobe);
        t0 = $time;
        chk(count, 4'h8);
        chk(req_n, 1'b0);
        @(negedge strobe);
        chk($time - t0, 16 * FSD_HALF_DIV * 100);
        for (int j = 0; j < 800 && dumps == d0; j++) @(posedge mclk_i);
        chk(dumps, d0 + 1);
        chk(frame, exp_frame());
        // fault still high: no second dump
        repeat (120) @(posedge mclk_i);
        chk(dumps, d0 + 1);
        chk_idle();
        fault_i <= 1'b0;
        repeat (100) @(posedge mclk_i);
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        chk_idle();
        t_clock();
        chk_idle();
        run_dump(12'hA5C, 12'h3E1, 5'h16, 5'h0B, 5'h19);
        run_dump(12'h5A3, 12'hC1E, 5'h09, 5'h14, 5'h06);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        give_verdict();
    end
endmodule // tb
